// *** spi_q_pkg.sv ***
// Shared constants and types of the queued serial engine.
// Assumes a 25 MHz core clock; pin levels are resolved by the surroundings.
package spi_q_pkg;

    localparam int PTR_W = 4;
    localparam int WORD_W = 16;
    localparam logic [3:0] PTR_RST = 4'h0;

    // Command byte layout.
    localparam int CMD_CS_HOLD_BIT = 7;
    localparam int CMD_LEN_OVR_BIT = 6;
    localparam int CMD_POST_DLY_BIT = 5;
    localparam int CMD_SEL_DLY_BIT = 4;
    localparam int CMD_PATTERN_LSB = 0;

    localparam logic [4:0] DEF_BITS = 5'h08;
    localparam logic [4:0] MAX_BITS = 5'h10;

    // Timing.
    localparam int CORE_CLK_NS = 40;
    localparam int STD_DELAY_NS = 1000;
    localparam int STD_DELAY_CYC =
        (STD_DELAY_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
    localparam logic [12:0] POST_DELAY_STEP = 13'h0020;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DELAY = 3'b011,
        ST_HALT  = 3'b100,
        ST_TGT   = 3'b101
    } eng_state_t;

    // Length code 0 means sixteen bits, codes below eight mean eight.
    function automatic logic [4:0] bits_of(input logic [3:0] code);
        if (code == 4'h0)
            return MAX_BITS;
        else if ({1'b0, code} < DEF_BITS)
            return DEF_BITS;
        else
            return {1'b0, code};
    endfunction

endpackage

// *** queue_ram.sv ***
// Sixteen-entry queue store: command byte, transmit word, receive word.
// Assumes the CPU and the engine never write the same segment at once.
`timescale 1ns/100ps
module queue_ram
(
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    nrst,
    // CPU side
    input  wire logic [3:0]              cpu_addr,
    input  wire logic                    cpu_cmd_write,
    input  wire logic [7:0]              cpu_cmd_wdata,
    input  wire logic                    cpu_tx_write,
    input  wire logic [15:0]             cpu_tx_wdata,
    output logic      [15:0]             cpu_rx_data,
    // Engine side
    input  wire logic [3:0]              eng_addr,
    output logic      [7:0]              eng_cmd,
    output logic      [15:0]             eng_tx,
    input  wire logic                    eng_rx_write,
    input  wire logic [3:0]              eng_rx_addr,
    input  wire logic [15:0]             eng_rx_wdata
);
    import spi_q_pkg::*;

    typedef struct packed {
        logic [15:0][7:0]  cmd;
        logic [15:0][15:0] tx;
        logic [15:0][15:0] rx;
    } ram_t;

    ram_t s;
    ram_t n;

    always_comb
    begin
        n = s;
        if (cpu_cmd_write)
            n.cmd[cpu_addr] = cpu_cmd_wdata;
        if (cpu_tx_write)
            n.tx[cpu_addr] = cpu_tx_wdata;
        if (eng_rx_write)
            n.rx[eng_rx_addr] = eng_rx_wdata;
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            s <= '0;
        else
            s <= n;
    end

    assign cpu_rx_data = s.rx[cpu_addr];
    assign eng_cmd = s.cmd[eng_addr];
    assign eng_tx = s.tx[eng_addr];

endmodule // queue_ram

// *** queued_spi_engine.sv ***
// Queue-driven serial engine for controller and target operation.
// Assumes the target-mode link clock is normalised so its rising edge samples.
//
// What this block does
// - Controller run starts at the start pointer, sends and stores there.
// - Idle level and sample edge pick SCK edges; divider and setup delay.
// - Controller words are eight bits unless the command overrides length.
// - After a word: store, copy pointer to done pointer, advance, load next.
// - With hold set, select pins keep pattern; new pattern at next start.
// - With hold clear, idle select levels are driven between transfers.
// - Post-transfer delay is programmed count times 32 cycles, else a standard one microsecond.
// - End of queue sets done flag and, when enabled, interrupt; no wrap stops the run.
// - With wrap, queue cycles on, run stays set, receive words overwritten.
// - Done flag and interrupt persist; enable only gates future requests.
// - Flag clears only by status read while set, then zero write.
// - Clearing wrap mid-run stops at the next end of queue.
// - Halt stops after the current word; clearing run aborts at once.
// - Target MISO floats while select is high, drives when low.
// - Target operation starts at the start pointer when selected.
// - Target mode ignores commands, drives no select pins, no delays.
// - Target word length comes from length code; long streams advance.
// - Target end of queue ignores bits or wraps to zero or start.
// - Deselect mid-word resumes the same entry at the next selection.
// - Target sends its transmit word MSB first on the link clock.
// - Target keeps exchanging until end of queue, equal bits each way.
// - The queue holds sixteen entries of command, transmit and receive.
// - Reset clears the working and done pointers to entry zero.
`timescale 1ns/100ps
module queued_spi_engine
(
    // Clocks and reset
    input  wire logic                    core_clk,
    input  wire logic                    nrst,
    input  wire logic                    tgt_sck_clk,
    // Configuration
    input  wire logic                    controller_select,
    input  wire logic                    clock_idle_level,
    input  wire logic                    clock_sample_edge,
    input  wire logic [7:0]              clock_divider,
    input  wire logic [6:0]              select_to_clock_delay_count,
    input  wire logic [7:0]              post_transfer_delay_count,
    input  wire logic [3:0]              length_code,
    input  wire logic [3:0]              idle_select_levels,
    input  wire logic                    wrap_enable,
    input  wire logic                    wrap_target_select,
    input  wire logic                    queue_done_irq_enable,
    input  wire logic                    halt_request,
    // Pointers
    input  wire logic [spi_q_pkg::PTR_W-1:0] queue_start_pointer,
    input  wire logic                    start_pointer_write,
    input  wire logic [spi_q_pkg::PTR_W-1:0] queue_last_pointer,
    output logic      [spi_q_pkg::PTR_W-1:0] queue_done_pointer,
    // Run and status
    input  wire logic                    run_write,
    input  wire logic                    run_wdata,
    output logic                         queue_run_enable,
    input  wire logic                    status_read,
    input  wire logic                    status_write,
    input  wire logic                    status_flag_wdata,
    output logic                         queue_done_flag,
    output logic                         queue_done_irq,
    output logic                         halted,
    // Queue store access
    input  wire logic [3:0]              cpu_addr,
    input  wire logic                    cpu_cmd_write,
    input  wire logic [7:0]              cpu_cmd_wdata,
    input  wire logic                    cpu_tx_write,
    input  wire logic [15:0]             cpu_tx_wdata,
    output logic      [15:0]             cpu_rx_rdata,
    // Serial pins
    output logic      [3:0]              select_out,
    output logic      [3:0]              select_oe_n,
    input  wire logic                    select0_or_target_select_in,
    output logic                         sck_out,
    output logic                         sck_oe_n,
    output logic                         mosi_out,
    output logic                         mosi_oe_n,
    input  wire logic                    mosi_in,
    output logic                         miso_out,
    output logic                         miso_oe_n,
    input  wire logic                    miso_in
);
    import spi_q_pkg::*;

    typedef struct packed {
        eng_state_t  st;
        logic        run;
        logic        flag;
        logic        armed;
        logic        irq;
        logic        halted;
        logic [3:0]  wptr;
        logic [3:0]  dptr;
        logic [3:0]  cs;
        logic        cs_hold;
        logic        post_dly;
        logic        sck;
        logic        mosi;
        logic        miso_oe_n;
        logic [15:0] tx_sh;
        logic [15:0] rx_sh;
        logic [4:0]  nbits;
        logic [5:0]  ecnt;
        logic [7:0]  hcnt;
        logic [12:0] dcnt;
        logic [1:0]  miso_s;
        logic [1:0]  sel_s;
        logic [2:0]  done_s;
        logic        pf;
        logic        rdy;
        logic [15:0] tx_hold;
        logic [15:0] rx_rd;
    } core_t;

    typedef struct packed {
        logic [1:0]  rdy_s;
        logic        seen;
        logic        active;
        logic [4:0]  cnt;
        logic [15:0] rx_sh;
        logic [15:0] tx_sh;
        logic [15:0] rx_hold;
        logic        done_tog;
        logic        miso;
    } link_t;

    core_t s;
    core_t n;
    link_t l;
    link_t ln;

    logic [7:0]  eng_cmd;
    logic [15:0] eng_tx;
    logic [15:0] cpu_rx_data;
    logic        rx_we;
    logic [15:0] rx_wd;
    logic        eoq_hit;
    logic        tgt_done;

    queue_ram u_ram
    (
        .core_clk     (core_clk),
        .nrst         (nrst),
        .cpu_addr     (cpu_addr),
        .cpu_cmd_write(cpu_cmd_write),
        .cpu_cmd_wdata(cpu_cmd_wdata),
        .cpu_tx_write (cpu_tx_write),
        .cpu_tx_wdata (cpu_tx_wdata),
        .cpu_rx_data  (cpu_rx_data),
        .eng_addr     (s.wptr),
        .eng_cmd      (eng_cmd),
        .eng_tx       (eng_tx),
        .eng_rx_write (rx_we),
        .eng_rx_addr  (s.wptr),
        .eng_rx_wdata (rx_wd)
    );

    // Half period of the controller clock, never below one cycle.
    function automatic logic [7:0] half_of(input logic [7:0] div);
        return (div == 8'h00) ? 8'h01 : div;
    endfunction

    // Loads the command at the working pointer and enters setup.
    function automatic core_t start_xfer(input core_t c);
        core_t       r;
        logic [4:0]  nb;
        logic [15:0] al;
        r = c;
        nb = eng_cmd[CMD_LEN_OVR_BIT] ? bits_of(length_code) : DEF_BITS;
        al = eng_tx << (MAX_BITS - nb);
        r.nbits = nb;
        r.cs = eng_cmd[CMD_PATTERN_LSB +: 4];
        r.cs_hold = eng_cmd[CMD_CS_HOLD_BIT];
        r.post_dly = eng_cmd[CMD_POST_DLY_BIT];
        r.dcnt = eng_cmd[CMD_SEL_DLY_BIT]
            ? 13'(select_to_clock_delay_count)
            : 13'(half_of(clock_divider));
        r.sck = clock_idle_level;
        r.ecnt = 6'h00;
        r.rx_sh = 16'h0000;
        r.tx_sh = al;
        if (!clock_sample_edge)
        begin
            r.mosi = al[15];
            r.tx_sh = al << 1;
        end
        r.st = ST_SETUP;
        return r;
    endfunction

    // Word completion: done pointer, end of queue, flag, wrap or stop.
    function automatic core_t finish(input core_t c);
        core_t r;
        r = c;
        r.dptr = c.wptr;
        if (c.wptr == queue_last_pointer)
        begin
            r.flag = 1'b1;
            r.irq = c.irq | queue_done_irq_enable;
            if (wrap_enable)
                r.wptr = wrap_target_select ? queue_start_pointer
                                            : PTR_RST;
            else
                r.run = 1'b0;
        end
        else
            r.wptr = c.wptr + 4'h1;
        return r;
    endfunction

    assign eoq_hit = rx_we && (s.wptr == queue_last_pointer);
    assign tgt_done = s.done_s[2] ^ s.done_s[1];

    always_comb
    begin
        n = s;
        rx_we = 1'b0;
        rx_wd = s.rx_sh;
        if (!s.run && s.st != ST_IDLE)
        begin
            n.st = ST_IDLE;
            n.sck = clock_idle_level;
            n.cs = idle_select_levels;
            n.halted = 1'b0;
        end
        else
        begin
            case (s.st)
            ST_IDLE:
            begin
                n.wptr = queue_start_pointer;
                n.cs = idle_select_levels;
                n.sck = clock_idle_level;
                if (s.run && controller_select)
                    n = start_xfer(s);
                else if (s.run)
                begin
                    n.st = ST_TGT;
                    n.pf = 1'b1;
                end
            end
            ST_SETUP:
            begin
                n.dcnt = s.dcnt - 13'h0001;
                if (s.dcnt <= 13'h0001)
                begin
                    n.st = ST_SHIFT;
                    n.hcnt = half_of(clock_divider);
                end
            end
            ST_SHIFT:
            begin
                n.hcnt = s.hcnt - 8'h01;
                if (s.hcnt <= 8'h01)
                begin
                    n.hcnt = half_of(clock_divider);
                    n.sck = ~s.sck;
                    n.ecnt = s.ecnt + 6'h01;
                    if (s.ecnt[0] == clock_sample_edge)
                        n.rx_sh = {s.rx_sh[14:0], s.miso_s[1]};
                    else
                    begin
                        n.mosi = s.tx_sh[15];
                        n.tx_sh = s.tx_sh << 1;
                    end
                    if (s.ecnt == {s.nbits, 1'b0} - 6'h01)
                    begin
                        rx_we = 1'b1;
                        rx_wd = n.rx_sh;
                        n = finish(n);
                        if (!s.cs_hold)
                            n.cs = idle_select_levels;
                        n.dcnt = s.post_dly
                            ? 13'(post_transfer_delay_count) * POST_DELAY_STEP
                            : 13'(STD_DELAY_CYC);
                        n.st = ST_DELAY;
                    end
                end
            end
            ST_DELAY:
            begin
                n.dcnt = s.dcnt - 13'h0001;
                if (s.dcnt <= 13'h0001)
                begin
                    if (halt_request)
                    begin
                        n.st = ST_HALT;
                        n.halted = 1'b1;
                    end
                    else
                        n = start_xfer(s);
                end
            end
            ST_HALT:
            begin
                if (!halt_request)
                begin
                    n = controller_select ? start_xfer(s) : s;
                    n.st = controller_select ? ST_SETUP : ST_TGT;
                    n.pf = !controller_select;
                    n.halted = 1'b0;
                end
            end
            ST_TGT:
            begin
                if (s.pf)
                begin
                    n.tx_hold = eng_tx;
                    n.nbits = bits_of(length_code);
                    n.rdy = ~s.rdy;
                    n.pf = 1'b0;
                end
                else if (tgt_done)
                begin
                    rx_we = 1'b1;
                    rx_wd = l.rx_hold;
                    n = finish(n);
                    if (halt_request)
                    begin
                        n.st = ST_HALT;
                        n.halted = 1'b1;
                    end
                    else
                        n.pf = n.run;
                end
            end
            default:
                n.st = ST_IDLE;
            endcase
        end
        n.miso_s = {s.miso_s[0], miso_in};
        n.sel_s = {s.sel_s[0], select0_or_target_select_in};
        n.done_s = {s.done_s[1:0], l.done_tog};
        n.rx_rd = cpu_rx_data;
        if (start_pointer_write)
            n.wptr = queue_start_pointer;
        if (run_write)
            n.run = run_wdata;
        if (status_read && s.flag)
            n.armed = 1'b1;
        if (status_write && !status_flag_wdata && s.armed
            && !(rx_we && s.wptr == queue_last_pointer))
        begin
            n.flag = 1'b0;
            n.irq = 1'b0;
        end
        if (status_write)
            n.armed = 1'b0;
        n.miso_oe_n = controller_select || !s.run
            || s.sel_s[1];
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            s <= '0;
            s.st <= ST_IDLE;
            s.wptr <= PTR_RST;
            s.dptr <= PTR_RST;
            s.cs <= 4'hf;
            s.sel_s <= 2'b11;
            s.miso_oe_n <= 1'b1;
        end
        else
            s <= n;
    end

    // Link side: sample and launch on the link clock while selected.
    always_comb
    begin
        logic        pend;
        logic [4:0]  cnt;
        logic [15:0] rx;
        pend = 1'b0;
        cnt = 5'h00;
        rx = 16'h0000;
        ln = l;
        ln.rdy_s = {l.rdy_s[0], s.rdy};
        pend = l.rdy_s[1] ^ l.seen;
        if (!select0_or_target_select_in && (pend || l.active))
        begin
            cnt = pend ? 5'h00 : l.cnt;
            rx = {l.rx_sh[14:0], mosi_in};
            if (pend)
            begin
                ln.seen = l.rdy_s[1];
                ln.miso = s.tx_hold[15];
                ln.tx_sh = s.tx_hold << 1;
            end
            else
            begin
                ln.miso = l.tx_sh[15];
                ln.tx_sh = l.tx_sh << 1;
            end
            ln.rx_sh = rx;
            ln.cnt = cnt + 5'h01;
            ln.active = 1'b1;
            if (cnt + 5'h01 == s.nbits)
            begin
                ln.rx_hold = rx;
                ln.done_tog = ~l.done_tog;
                ln.active = 1'b0;
            end
        end
    end

    always_ff @(posedge tgt_sck_clk or negedge nrst)
    begin
        if (!nrst)
            l <= '0;
        else
            l <= ln;
    end

    assign queue_done_pointer = s.dptr;
    assign queue_run_enable = s.run;
    assign queue_done_flag = s.flag;
    assign queue_done_irq = s.irq;
    assign halted = s.halted;
    assign cpu_rx_rdata = s.rx_rd;
    assign select_out = s.cs;
    assign select_oe_n = {4{~controller_select}};
    assign sck_out = s.sck;
    assign sck_oe_n = ~controller_select;
    assign mosi_out = s.mosi;
    assign mosi_oe_n = ~controller_select;
    assign miso_out = l.miso;
    assign miso_oe_n = s.miso_oe_n;

    sequence end_hit_s;
        eoq_hit;
    endsequence

    flag_set_a: assert property (@(posedge core_clk) disable iff (!nrst)
        end_hit_s |=> queue_done_flag)
        else $error("done flag not set at end of queue");
    stop_nowrap_a: assert property (@(posedge core_clk) disable iff (!nrst)
        end_hit_s and !wrap_enable and !run_write |=> !queue_run_enable)
        else $error("run not cleared at end without wrap");
    wrap_keeps_a: assert property (@(posedge core_clk) disable iff (!nrst)
        end_hit_s and wrap_enable and !run_write |=> queue_run_enable)
        else $error("run cleared during wrap");
    clear_order_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $fell(queue_done_flag) |-> $past(s.armed) && $past(status_write))
        else $error("flag cleared without read then write");
    abort_run_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !queue_run_enable |=> s.st == ST_IDLE)
        else $error("engine active after run cleared");
    tgt_nosel_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !controller_select |-> select_oe_n == 4'hf && sck_oe_n)
        else $error("target mode drives select or clock");
    miso_float_a: assert property (@(posedge core_clk) disable iff (!nrst)
        s.sel_s[1] ##1 s.sel_s[1] |-> miso_oe_n)
        else $error("miso driven while not selected");
    idle_sel_a: assert property (@(posedge core_clk) disable iff (!nrst)
        s.st == ST_DELAY && !s.cs_hold |-> select_out == idle_select_levels)
        else $error("idle levels not driven between words");
    hold_sel_a: assert property (@(posedge core_clk) disable iff (!nrst)
        s.st == ST_SHIFT ##1 s.st == ST_DELAY && s.cs_hold
        |-> $stable(select_out))
        else $error("held select pattern changed");
    done_ptr_a: assert property (@(posedge core_clk) disable iff (!nrst)
        rx_we |=> queue_done_pointer == $past(s.wptr))
        else $error("done pointer not updated");

endmodule // queued_spi_engine

// *** spi_peripheral_model.sv ***
// Behavioural peripheral on the far side of the serial link.
// Assumes idle-low clock, sampling on the rising edge, active-low select.
`timescale 1ns/100ps
module spi_peripheral_model
#(
    parameter logic [15:0] REPLY = 16'h5ac3
)
(
    // Link pins
    input  wire logic        sck,
    input  wire logic        sel_n,
    input  wire logic        mosi,
    output logic             miso,
    // Observation
    output logic [15:0]      last_rx,
    output logic [7:0]       frames
);
    logic [15:0] out_q;

    initial
    begin
        miso = 1'b0;
        last_rx = 16'h0000;
        frames = 8'h00;
        out_q = 16'h0000;
    end

    // The reply starts with its top bit as soon as the select falls.
    always @(negedge sel_n)
    begin
        miso = REPLY[15];
        out_q = REPLY << 1;
    end

    // A released line shows the inverse of its last bit.
    always @(posedge sel_n)
    begin
        miso = ~miso;
        frames = frames + 8'h01;
    end

    always @(posedge sck)
        if (!sel_n)
            last_rx = {last_rx[14:0], mosi};

    always @(negedge sck)
        if (!sel_n)
        begin
            miso = out_q[15];
            out_q = out_q << 1;
        end
endmodule // spi_peripheral_model

// *** test_queued_spi_engine.sv ***
// Bench for the queued serial engine in controller and target mode.
// Assumes the package, the engine and the peripheral model compiled first.
`timescale 1ns/100ps
module test_queued_spi_engine;
    import spi_q_pkg::*;
    typedef struct packed {
        logic [7:0]  cmd;
        logic [15:0] tx;
        logic [15:0] rx;
        logic [15:0] msk;
    } row_t;
    localparam row_t ROWS [2] = '{
        '{8'h0e, 16'h3c00, 16'h005a, 16'h00ff},
        '{8'h7e, 16'h9617, 16'h5ac3, 16'hffff}};
    logic        core_clk, nrst, tgt_sck_clk, controller_select;
    logic        clock_idle_level, clock_sample_edge, wrap_enable;
    logic        wrap_target_select, queue_done_irq_enable, halt_request;
    logic        start_pointer_write, run_write, run_wdata, status_read;
    logic        status_write, status_flag_wdata, cpu_cmd_write;
    logic        cpu_tx_write, mosi_in, miso_in, tgt_sel_n, sck_out;
    logic        mosi_out, miso_out, queue_run_enable, queue_done_flag;
    logic        queue_done_irq, miso_oe_n;
    logic [7:0]  clock_divider, post_transfer_delay_count, cpu_cmd_wdata;
    logic [6:0]  select_to_clock_delay_count;
    logic [3:0]  length_code, idle_select_levels, queue_start_pointer;
    logic [3:0]  queue_last_pointer, queue_done_pointer, cpu_addr;
    logic [3:0]  select_out, select_oe_n;
    logic [15:0] cpu_tx_wdata, cpu_rx_rdata, last_rx;
    logic [7:0]  frames, f0, got;
    wire         sel0 = select_oe_n[0] ? tgt_sel_n : select_out[0];
    int          checks, mismatches, i;

    queued_spi_engine dut (.core_clk, .nrst, .tgt_sck_clk, .controller_select,
        .clock_idle_level, .clock_sample_edge, .clock_divider,
        .select_to_clock_delay_count, .post_transfer_delay_count,
        .length_code, .idle_select_levels, .wrap_enable, .wrap_target_select,
        .queue_done_irq_enable, .halt_request, .queue_start_pointer,
        .start_pointer_write, .queue_last_pointer, .queue_done_pointer,
        .run_write, .run_wdata, .queue_run_enable, .status_read,
        .status_write, .status_flag_wdata, .queue_done_flag, .queue_done_irq,
        .halted(), .cpu_addr, .cpu_cmd_write, .cpu_cmd_wdata, .cpu_tx_write,
        .cpu_tx_wdata, .cpu_rx_rdata, .select_out, .select_oe_n,
        .select0_or_target_select_in(sel0), .sck_out, .sck_oe_n(),
        .mosi_out, .mosi_oe_n(), .mosi_in, .miso_out, .miso_oe_n, .miso_in);
    spi_peripheral_model model (.sck(sck_out), .sel_n(sel0),
        .mosi(mosi_out), .miso(miso_in), .last_rx, .frames);

    always #20 core_clk = ~core_clk;

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v);
        checks++;
        if (got_v !== exp_v)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got_v, exp_v);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wait_flag();
        for (i = 0; i < 3000 && queue_done_flag !== 1'b1; i++)
            tick(1);
        if (i == 3000)
        begin
            mismatches++;
            print_verdict();
        end
    endtask

    task automatic run_set(input logic v);
        run_write <= 1'b1;
        run_wdata <= v;
        tick(1);
        run_write <= 1'b0;
    endtask

    // One byte on the link clock; miso is taken on each falling edge.
    task automatic link_byte(input logic [7:0] d);
        for (int k = 7; k >= 0; k--)
        begin
            mosi_in = d[k];
            #80 tgt_sck_clk = 1'b1;
            #80 tgt_sck_clk = 1'b0;
            got = {got[6:0], miso_out};
        end
    endtask

    initial
    begin
        {core_clk, nrst, tgt_sck_clk, run_write, run_wdata} = '0;
        {clock_idle_level, clock_sample_edge, halt_request} = '0;
        {wrap_enable, wrap_target_select, start_pointer_write} = '0;
        {status_read, status_write, status_flag_wdata, mosi_in} = '0;
        {cpu_cmd_write, cpu_tx_write, cpu_addr, length_code} = '0;
        {cpu_cmd_wdata, cpu_tx_wdata, queue_start_pointer} = '0;
        {controller_select, queue_done_irq_enable, tgt_sel_n} = 3'h7;
        clock_divider = 8'h04;
        post_transfer_delay_count = 8'h01;
        select_to_clock_delay_count = 7'h03;
        idle_select_levels = 4'hf;
        queue_last_pointer = 4'h1;
        tick(3);
        nrst <= 1'b1;
        tick(2);
        chk({12'h000, queue_done_pointer}, 16'h0000);
        for (i = 0; i < 2; i++)
        begin
            cpu_addr <= i[3:0];
            cpu_cmd_wdata <= ROWS[i].cmd;
            cpu_tx_wdata <= ROWS[i].tx;
            {cpu_cmd_write, cpu_tx_write} <= 2'b11;
            tick(1);
        end
        {cpu_cmd_write, cpu_tx_write} <= 2'b00;
        f0 = frames;
        run_set(1'b1);
        wait_flag();
        tick(2);
        chk({11'h0, queue_done_pointer, queue_run_enable}, 16'h0002);
        chk({8'h00, frames - f0}, 16'h0002);
        chk(last_rx, ROWS[1].tx);
        chk({15'h0, queue_done_irq}, 16'h0001);
        for (i = 0; i < 2; i++)
        begin
            cpu_addr <= i[3:0];
            tick(2);
            chk(cpu_rx_rdata & ROWS[i].msk, ROWS[i].rx);
        end
        $display("test controller queue done");
        queue_done_irq_enable <= 1'b0;
        status_write <= 1'b1;
        tick(1);
        status_write <= 1'b0;
        tick(2);
        chk({14'h0, queue_done_flag, queue_done_irq}, 16'h0003);
        status_read <= 1'b1;
        tick(1);
        status_read <= 1'b0;
        status_write <= 1'b1;
        tick(1);
        status_write <= 1'b0;
        tick(2);
        chk({14'h0, queue_done_flag, queue_done_irq}, 16'h0000);
        $display("test flag clear done");
        controller_select <= 1'b0;
        length_code <= 4'h8;
        queue_last_pointer <= 4'h0;
        start_pointer_write <= 1'b1;
        tick(1);
        start_pointer_write <= 1'b0;
        run_set(1'b1);
        tick(6);
        chk({15'h0, miso_oe_n}, 16'h0001);
        #7;
        link_byte(8'h00);
        tgt_sel_n = 1'b0;
        #200;
        chk({15'h0, miso_oe_n}, 16'h0000);
        link_byte(8'ha6);
        chk({8'h00, got}, {8'h00, ROWS[0].tx[15:8]});
        tgt_sel_n = 1'b1;
        tick(12);
        cpu_addr <= 4'h0;
        tick(2);
        chk(cpu_rx_rdata & 16'h00ff, 16'h00a6);
        chk({12'h0, queue_run_enable, queue_done_flag, queue_done_irq,
            miso_oe_n}, 16'h0005);
        $display("test target word done");
        print_verdict();
    end
endmodule // test_queued_spi_engine
